/* jksq_sequencer.sv */
// J-K sequencer registers, product-term array, initialization, output enable and diagnostics
`timescale 1ns/1ps
`include "jksq_defs.svh"

module jksq_sequencer #(
	parameter int N_TERMS = `JKSQ_N_TERMS,
	parameter int N_BITS  = `JKSQ_N_BITS
) (
	input  wire logic                    clk_i,
	input  wire logic                    rst_b_i,
	input  wire logic [`JKSQ_N_IN-1:0]   logic_in_i,
	input  wire logic                    first_clock_i,
	input  wire logic                    second_clock_i,
	input  wire logic                    init_oe_pin_i,
	input  wire logic                    output_reg_load_select_i,
	input  wire logic                    state_reg_load_select_i,
	input  wire logic                    state_view_select_i,
	input  wire logic [`JKSQ_N_BITS-1:0] registered_output_pins_i,
	input  wire jksq_pkg::jksq_fuse_s    fuse_i,
	output logic [`JKSQ_N_BITS-1:0]      registered_output_pins_o,
	output logic                         registered_output_pins_oe_b_o,
	output logic [`JKSQ_N_BITS-1:0]      state_bits_o,
	output logic [`JKSQ_N_BITS-1:0]      output_reg_bits_o
);
	import jksq_pkg::*;

	// The fuse map is a fixed-size struct, so other sizes cannot be served
	if (N_TERMS != `JKSQ_N_TERMS || N_BITS != `JKSQ_N_BITS) begin : g_chk
		$error("jksq_sequencer: N_TERMS and N_BITS must match the fuse map");
	end

	// ------------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------------
	jksq_pins_s                pin_meta_q;
	jksq_pins_s                pin_meta_d;
	jksq_pins_s                pin_q;
	jksq_pins_s                pin_d;

	logic                      cfg_oe_mode;
	logic                      cfg_second_clock_on;
	logic [`JKSQ_N_FF-1:0]     cfg_preset;
	logic                      init_act;
	logic                      oe_off;
	logic                      load_any;

	logic [`JKSQ_N_COMP-1:0]   cmp;
	logic [`JKSQ_LIT_W-1:0]    lit;
	logic [N_TERMS-1:0]        term_pre;
	logic [N_TERMS-1:0]        term_all;
	logic [`JKSQ_N_FF-1:0]     jv;
	logic [`JKSQ_N_FF-1:0]     kv;

	logic [1:0]                dev_clk;
	logic [1:0]                upd;
	logic [N_BITS-1:0]         lane_upd;

	logic [N_BITS-1:0]         st_q;
	logic [N_BITS-1:0]         st_d;
	logic [N_BITS-1:0]         of_q;
	logic [N_BITS-1:0]         of_d;
	logic [N_BITS-1:0]         pad_q;
	logic [N_BITS-1:0]         pad_d;
	logic                      oe_b_q;
	logic                      oe_b_d;

	// ------------------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------------------
	// One AND term; complement literals can be masked for the first pass
	function automatic logic term_hit(input jksq_term_s t,
					  input logic [`JKSQ_LIT_W-1:0] v,
					  input logic use_cmp);
		logic [`JKSQ_LIT_W-1:0] keep;
		keep = '1;
		if (!use_cmp) begin
			keep[`JKSQ_LIT_W-1:`JKSQ_LIT_CMP_LSB] = '0;
		end
		term_hit = (&(~(t.true_m & keep) | v)) & (&(~(t.false_m & keep) | ~v));
	endfunction

	function automatic logic jk_next(input logic q, input logic j, input logic k);
		case ({j, k})
			2'b00:   jk_next = q;
			2'b01:   jk_next = 1'b0;
			2'b10:   jk_next = 1'b1;
			default: jk_next = ~q;
		endcase
	endfunction

	// ------------------------------------------------------------------------
	// Pin synchroniser
	// ------------------------------------------------------------------------
	always_comb begin
		pin_meta_d.logic_in         = logic_in_i;
		pin_meta_d.init_oe          = init_oe_pin_i;
		pin_meta_d.diag.out_load    = output_reg_load_select_i;
		pin_meta_d.diag.state_load  = state_reg_load_select_i;
		pin_meta_d.diag.state_view  = state_view_select_i;
		pin_meta_d.pads             = registered_output_pins_i;
		pin_d                       = pin_meta_q;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			pin_meta_q <= '0;
			pin_q      <= '0;
		end else begin
			pin_meta_q <= pin_meta_d;
			pin_q      <= pin_d;
		end
	end

	// ------------------------------------------------------------------------
	// Effective configuration
	// ------------------------------------------------------------------------
	always_comb begin
		// An unprogrammed part behaves as initialization with clock 2 off
		cfg_oe_mode = fuse_i.programmed & fuse_i.oe_mode;
		cfg_second_clock_on = fuse_i.programmed & fuse_i.second_clock_used;
		cfg_preset  = fuse_i.programmed ? fuse_i.init_preset : `JKSQ_VIRGIN_PRESET;
		// One shared pin, two exclusive meanings
		init_act    = ~cfg_oe_mode & pin_q.init_oe;
		oe_off      = cfg_oe_mode & pin_q.init_oe;
		load_any    = pin_q.diag.out_load | pin_q.diag.state_load;
	end

	// ------------------------------------------------------------------------
	// Product-term array
	// ------------------------------------------------------------------------
	assign lit = {cmp, st_q, pin_q.logic_in};

	// Complement arrays are fed by a first pass that ignores complement
	// literals; this breaks the loop a term would otherwise form through them
	genvar gt;
	for (gt = 0; gt < N_TERMS; gt++) begin : g_term
		assign term_pre[gt] = fuse_i.programmed & term_hit(fuse_i.term[gt], lit, 1'b0);
		assign term_all[gt] = fuse_i.programmed & term_hit(fuse_i.term[gt], lit, 1'b1);
	end

	genvar gc;
	for (gc = 0; gc < `JKSQ_N_COMP; gc++) begin : g_cmp
		assign cmp[gc] = ~|(term_pre & fuse_i.comp_or[gc]);
	end

	genvar gf;
	for (gf = 0; gf < `JKSQ_N_FF; gf++) begin : g_jk
		localparam logic [`JKSQ_N_FF-1:0] TEST_J = `JKSQ_TEST_J;
		localparam logic [`JKSQ_N_FF-1:0] TEST_K = `JKSQ_TEST_K;
		// Unprogrammed fuses are disabled and the test array takes over
		assign jv[gf] = fuse_i.programmed ? |(term_all & fuse_i.j_or[gf])
						  : TEST_J[gf];
		assign kv[gf] = fuse_i.programmed ? |(term_all & fuse_i.k_or[gf])
						  : TEST_K[gf];
	end

	// ------------------------------------------------------------------------
	// Device clocks
	// ------------------------------------------------------------------------
	assign dev_clk = {second_clock_i, first_clock_i};

	genvar gk;
	for (gk = 0; gk < 2; gk++) begin : g_gate
		jksq_clk_gate #(
			.SYNC_STAGES (`JKSQ_SYNC_STAGES)
		) u_gate (
			.clk_i     (clk_i),
			.rst_b_i   (rst_b_i),
			.dev_clk_i (dev_clk[gk]),
			.init_i    (init_act),
			.upd_o     (upd[gk])
		);
	end

	// Bits 4-7 follow the second clock only when it is configured
	genvar gb;
	for (gb = 0; gb < N_BITS; gb++) begin : g_lane
		if (gb >= `JKSQ_SECOND_CLOCK_LSB) begin : g_hi
			assign lane_upd[gb] = cfg_second_clock_on ? upd[1] : upd[0];
		end else begin : g_lo
			assign lane_upd[gb] = upd[0];
		end
	end

	// ------------------------------------------------------------------------
	// State and output registers
	// ------------------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		of_d = of_q;
		if (init_act) begin
			// Held at the preset pattern, all ones when unprogrammed; clock edges have no effect
			st_d = cfg_preset[N_BITS-1:0];
			of_d = cfg_preset[`JKSQ_FF_OUT_LSB +: N_BITS];
		end else begin
			for (int b = 0; b < N_BITS; b++) begin
				if (lane_upd[b]) begin
					if (pin_q.diag.state_load) begin
						st_d[b] = pin_q.pads[b];
					end else if (!pin_q.diag.out_load && !pin_q.diag.state_view) begin
						st_d[b] = jk_next(st_q[b], jv[b], kv[b]);
					end
					if (pin_q.diag.out_load) begin
						of_d[b] = pin_q.pads[b];
					end else if (!pin_q.diag.state_load && !pin_q.diag.state_view) begin
						of_d[b] = jk_next(of_q[b], jv[b + `JKSQ_FF_OUT_LSB],
								  kv[b + `JKSQ_FF_OUT_LSB]);
					end
				end
			end
		end
	end

	// ------------------------------------------------------------------------
	// Pin drivers
	// ------------------------------------------------------------------------
	always_comb begin
		// Viewing is ignored during initialization, as the pins then show
		// the initialized output register
		if (pin_q.diag.state_view && !init_act) begin
			pad_d = st_d;
		end else begin
			pad_d = of_d;
		end
		// Floating the drivers while loading avoids fighting the tester
		oe_b_d = (load_any & ~init_act) | oe_off;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			st_q   <= N_BITS'(`JKSQ_POWERUP);
			of_q   <= N_BITS'(`JKSQ_POWERUP >> `JKSQ_FF_OUT_LSB);
			pad_q  <= N_BITS'(`JKSQ_POWERUP >> `JKSQ_FF_OUT_LSB);
			oe_b_q <= 1'b0;
		end else begin
			st_q   <= st_d;
			of_q   <= of_d;
			pad_q  <= pad_d;
			oe_b_q <= oe_b_d;
		end
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------
	assign registered_output_pins_o      = pad_q;
	assign registered_output_pins_oe_b_o = oe_b_q;
	assign state_bits_o                  = st_q;
	assign output_reg_bits_o             = of_q;

endmodule

/* jksq_defs.svh */
// Shared constants of the J-K sequencer: sizes, literal layout, reset and test values
`ifndef JKSQ_DEFS_SVH
`define JKSQ_DEFS_SVH

// ----------------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------------
`define JKSQ_N_BITS        8
`define JKSQ_N_FF          16
`define JKSQ_N_IN          16
`define JKSQ_N_TERMS       64
`define JKSQ_N_COMP        2
`define JKSQ_SYNC_STAGES   2

// ----------------------------------------------------------------------------
// Literal vector seen by every product term: inputs, state bits, complements
// ----------------------------------------------------------------------------
`define JKSQ_LIT_W         26
`define JKSQ_LIT_IN_LSB    0
`define JKSQ_LIT_ST_LSB    16
`define JKSQ_LIT_CMP_LSB   24

// ----------------------------------------------------------------------------
// Flip-flop layout: state bits at 7:0, output register bits at 15:8
// ----------------------------------------------------------------------------
`define JKSQ_FF_OUT_LSB    8
`define JKSQ_SECOND_CLOCK_LSB      4

// ----------------------------------------------------------------------------
// Reset and fixed patterns
// ----------------------------------------------------------------------------
`define JKSQ_POWERUP       16'hffff
`define JKSQ_VIRGIN_PRESET 16'hffff
`define JKSQ_TEST_J        16'hffff
`define JKSQ_TEST_K        16'hffff

`endif

/* jksq_pkg.sv */
// Types shared by the J-K sequencer modules
package jksq_pkg;

`include "jksq_defs.svh"

	// One product term: a set bit in true_m asks for the literal high,
	// in false_m for the literal low; both set makes the term inactive
	typedef struct packed {
		logic [`JKSQ_LIT_W-1:0] true_m;
		logic [`JKSQ_LIT_W-1:0] false_m;
	} jksq_term_s;

	// Programmed configuration, static while the device runs
	typedef struct packed {
		logic                                       programmed;
		logic                                       oe_mode;
		logic                                       second_clock_used;
		logic [`JKSQ_N_FF-1:0]                      init_preset;
		jksq_term_s [`JKSQ_N_TERMS-1:0]             term;
		logic [`JKSQ_N_COMP-1:0][`JKSQ_N_TERMS-1:0] comp_or;
		logic [`JKSQ_N_FF-1:0][`JKSQ_N_TERMS-1:0]   j_or;
		logic [`JKSQ_N_FF-1:0][`JKSQ_N_TERMS-1:0]   k_or;
	} jksq_fuse_s;

	// High-voltage diagnostic selects
	typedef struct packed {
		logic out_load;
		logic state_load;
		logic state_view;
	} jksq_diag_s;

	// Bundle of pin levels passed through the synchroniser
	typedef struct packed {
		logic [`JKSQ_N_IN-1:0]   logic_in;
		logic                    init_oe;
		jksq_diag_s              diag;
		logic [`JKSQ_N_BITS-1:0] pads;
	} jksq_pins_s;

	typedef enum logic [1:0] {
		GATE_RUN,
		GATE_HOLD,
		GATE_ARM
	} jksq_gate_e;

endpackage

/* jksq_clk_gate.sv */
// Device clock synchroniser, edge detector and initialization resume gate
`timescale 1ns/1ps
`include "jksq_defs.svh"

module jksq_clk_gate #(
	parameter int SYNC_STAGES = `JKSQ_SYNC_STAGES
) (
	input  wire logic clk_i,
	input  wire logic rst_b_i,
	input  wire logic dev_clk_i,
	input  wire logic init_i,
	output logic      upd_o
);
	import jksq_pkg::*;

	if (SYNC_STAGES < 2) begin : g_chk
		$error("jksq_clk_gate: SYNC_STAGES must be at least 2");
	end

	logic [SYNC_STAGES-1:0] sync_q;
	logic [SYNC_STAGES-1:0] sync_d;
	logic                   prev_q;
	logic                   prev_d;
	jksq_gate_e             state_q;
	jksq_gate_e             state_d;
	logic                   upd_q;
	logic                   upd_d;
	logic                   rise;
	logic                   fall;

	assign upd_o = upd_q;

	// ------------------------------------------------------------------------
	// Next values
	// ------------------------------------------------------------------------
	always_comb begin
		sync_d  = {sync_q[SYNC_STAGES-2:0], dev_clk_i};
		prev_d  = sync_q[SYNC_STAGES-1];
		rise    = sync_q[SYNC_STAGES-1] & ~prev_q;
		fall    = ~sync_q[SYNC_STAGES-1] & prev_q;
		state_d = state_q;
		upd_d   = 1'b0;
		case (state_q)
			GATE_RUN: begin
				if (init_i) begin
					state_d = GATE_HOLD;
				end else begin
					upd_d = rise;
				end
			end
			GATE_HOLD: begin
				// Edges seen while held are dropped, not queued
				if (!init_i) begin
					state_d = GATE_ARM;
				end
			end
			GATE_ARM: begin
				// A rise right after release is only half a pulse: wait for a fall
				if (init_i) begin
					state_d = GATE_HOLD;
				end else if (fall) begin
					state_d = GATE_RUN;
				end
			end
			default: begin
				state_d = GATE_HOLD;
			end
		endcase
	end

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			sync_q  <= '0;
			prev_q  <= 1'b0;
			state_q <= GATE_RUN;
			upd_q   <= 1'b0;
		end else begin
			sync_q  <= sync_d;
			prev_q  <= prev_d;
			state_q <= state_d;
			upd_q   <= upd_d;
		end
	end

endmodule

/* jksq_sequencer_sva.sv */
// Concurrent checks on the pins of the J-K sequencer
`timescale 1ns/1ps

module jksq_sequencer_sva #(
	parameter int N_TERMS = 64,
	parameter int N_BITS  = 8
) (
	input  wire logic                 clk_i,
	input  wire logic                 rst_b_i,
	input  wire logic                 first_clock_i,
	input  wire logic                 second_clock_i,
	input  wire logic                 init_oe_pin_i,
	input  wire logic                 output_reg_load_select_i,
	input  wire logic                 state_reg_load_select_i,
	input  wire logic                 state_view_select_i,
	input  wire jksq_pkg::jksq_fuse_s fuse_i,
	input  wire logic [7:0]           registered_output_pins_o,
	input  wire logic                 registered_output_pins_oe_b_o,
	input  wire logic [7:0]           state_bits_o,
	input  wire logic [7:0]           output_reg_bits_o
);
	import jksq_pkg::*;

	logic       init_act;
	logic       oe_act;
	logic       load_act;
	logic [3:0] calm_q;
	logic [3:0] calm_d;

	assign init_act = init_oe_pin_i && !(fuse_i.programmed && fuse_i.oe_mode);
	assign oe_act   = init_oe_pin_i && fuse_i.programmed && fuse_i.oe_mode;
	assign load_act = output_reg_load_select_i || state_reg_load_select_i;

	// Cycles with both device clocks low and no initialization; any rise older
	// than eight cycles has landed, so the registers must then sit still
	always_comb begin
		calm_d = calm_q;
		if (first_clock_i || second_clock_i || init_act) begin
			calm_d = 4'h0;
		end else if (calm_q != 4'hf) begin
			calm_d = calm_q + 4'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			calm_q <= 4'h0;
		end else begin
			calm_q <= calm_d;
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	sequence s_normal_held;
		(!load_act && !oe_act && !state_view_select_i) [*6];
	endsequence
	sequence s_view_held;
		(state_view_select_i && !load_act && !init_act && !oe_act) [*6];
	endsequence
	sequence s_out_load_held;
		(output_reg_load_select_i && !state_reg_load_select_i && !init_act) [*8];
	endsequence
	sequence s_state_load_held;
		(state_reg_load_select_i && !output_reg_load_select_i && !init_act) [*8];
	endsequence

	a_pins_show_out: assert property (
		s_normal_held |-> registered_output_pins_o == output_reg_bits_o)
		else $error("pins differ from output register");
	a_view_shows_state: assert property (
		s_view_held |-> registered_output_pins_o == state_bits_o)
		else $error("pins differ from state bits in view mode");
	a_load_floats: assert property (
		load_act [*5] |-> registered_output_pins_oe_b_o)
		else $error("pins driven during a load mode");
	a_oe_floats: assert property (
		oe_act [*5] |-> registered_output_pins_oe_b_o)
		else $error("pins driven with output enable high");
	a_pins_driven: assert property (
		(!load_act && !oe_act) [*5] |-> !registered_output_pins_oe_b_o)
		else $error("pins floating in normal mode");
	a_init_preset: assert property (
		init_act [*5] |-> {output_reg_bits_o, state_bits_o} ==
			(fuse_i.programmed ? fuse_i.init_preset : 16'hffff))
		else $error("registers not at preset during init");
	a_regs_need_clock: assert property (
		calm_q >= 4'h8 |-> $stable(state_bits_o) && $stable(output_reg_bits_o))
		else $error("register changed without a clock edge");
	a_out_load_keeps: assert property (
		s_out_load_held |-> $stable(state_bits_o))
		else $error("state bits changed in output load mode");
	a_state_load_keeps: assert property (
		s_state_load_held |-> $stable(output_reg_bits_o))
		else $error("output register changed in state load mode");
endmodule

bind jksq_sequencer jksq_sequencer_sva #(.N_TERMS(N_TERMS), .N_BITS(N_BITS)) jksq_sequencer_sva_i (
	.clk_i(clk_i), .rst_b_i(rst_b_i), .first_clock_i(first_clock_i),
	.second_clock_i(second_clock_i), .init_oe_pin_i(init_oe_pin_i),
	.output_reg_load_select_i(output_reg_load_select_i),
	.state_reg_load_select_i(state_reg_load_select_i),
	.state_view_select_i(state_view_select_i), .fuse_i(fuse_i),
	.registered_output_pins_o(registered_output_pins_o),
	.registered_output_pins_oe_b_o(registered_output_pins_oe_b_o),
	.state_bits_o(state_bits_o), .output_reg_bits_o(output_reg_bits_o)
);

/* jksq_far_end.sv */
// Surrounding logic and tester standing at the pins of the sequencer
`timescale 1ns/1ps

module jksq_far_end (
	input  wire logic       clk_i,
	input  wire logic [7:0] dev_pins_i,
	input  wire logic       dev_oe_b_i,
	output logic            first_clock_o,
	output logic            second_clock_o,
	output logic [7:0]      pad_o
);
	logic       drive_en;
	logic [7:0] drive_val;
	logic [7:0] last_q;

	// Floating pins show the inverse of the last level so a stale value cannot pass
	assign pad_o = !dev_oe_b_i ? dev_pins_i : (drive_en ? drive_val : ~last_q);

	initial begin
		first_clock_o = 1'b0;
		second_clock_o = 1'b0;
		drive_en = 1'b0;
		drive_val = 8'h00;
		last_q = 8'h00;
	end

	always @(posedge clk_i) begin
		if (!dev_oe_b_i || drive_en) begin
			last_q <= pad_o;
		end
	end

	// Device clocks stand low outside a pulse; high and low last four cycles each
	task automatic pulse(input logic use_second);
		if (use_second) begin
			second_clock_o = 1'b1;
		end else begin
			first_clock_o = 1'b1;
		end
		repeat (4) @(posedge clk_i);
		#2;
		first_clock_o = 1'b0;
		second_clock_o = 1'b0;
		repeat (4) @(posedge clk_i);
		#2;
	endtask

	// The tester forces the pins once the device has let go of them, or after 20 cycles of waiting
	task automatic drive(input logic [7:0] val);
		int n;
		n = 0;
		while (dev_oe_b_i !== 1'b1 && n < 20) begin
			@(posedge clk_i);
			#2;
			n++;
		end
		drive_val = val;
		drive_en = 1'b1;
	endtask

	task automatic let_go();
		drive_en = 1'b0;
	endtask
endmodule

/* tb_jksq_sequencer.sv */
// Self-checking testbench of the J-K sequencer
`timescale 1ns/1ps

module tb_jksq_sequencer;
	import jksq_pkg::*;

	logic       clk_i;
	logic       rst_b_i;
	logic       first_clock;
	logic       second_clock;
	logic       init_oe_pin;
	logic       out_load;
	logic       state_load;
	logic       state_view;
	logic [7:0] pad;
	logic [15:0] logic_in;
	logic [7:0] pins_o;
	logic       oe_b;
	logic [7:0] state_bits;
	logic [7:0] out_bits;
	logic [7:0] es;
	logic [7:0] eo;
	jksq_fuse_s fuse;
	int         n_mismatch = 0;
	int         total_checks = 0;
	int         cycles = 0;

	jksq_sequencer jksq_sequencer_i (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .logic_in_i(logic_in),
		.first_clock_i(first_clock), .second_clock_i(second_clock),
		.init_oe_pin_i(init_oe_pin), .output_reg_load_select_i(out_load),
		.state_reg_load_select_i(state_load), .state_view_select_i(state_view),
		.registered_output_pins_i(pad), .fuse_i(fuse), .registered_output_pins_o(pins_o),
		.registered_output_pins_oe_b_o(oe_b), .state_bits_o(state_bits),
		.output_reg_bits_o(out_bits)
	);

	jksq_far_end jksq_far_end_i (
		.clk_i(clk_i), .dev_pins_i(pins_o), .dev_oe_b_i(oe_b),
		.first_clock_o(first_clock), .second_clock_o(second_clock), .pad_o(pad)
	);

	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 2000) begin
			n_mismatch++;
			test_done();
		end
	end

	task automatic test_done();
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
		#2;
	endtask

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Lanes 0-1 hold, 2-3 clear, 4-5 set, 6-7 toggle; only lanes in m move
	function automatic logic [7:0] nxt(input logic [7:0] s, input logic [7:0] m);
		return (((s & 8'h03) | 8'h30 | (~s & 8'hc0)) & m) | (s & ~m);
	endfunction

	// Product term 0 has no literal and is always on; all others are inactive
	task automatic set_fuse(input logic prog, input logic oe, input logic c2);
		int f;
		fuse = '0;
		fuse.programmed = prog;
		fuse.oe_mode = oe;
		fuse.second_clock_used = c2;
		fuse.init_preset = 16'h5a3c;
		for (f = 1; f < 64; f++) begin
			fuse.term[f] = '1;
		end
		for (f = 0; f < 16; f++) begin
			fuse.j_or[f][0] = f[2];
			fuse.k_or[f][0] = f[1];
		end
	endtask

	task automatic t_reset_virgin();
		check("regs at reset", {out_bits, state_bits}, 16'hffff);
		check("pins at reset", {7'h00, oe_b, pins_o}, 16'h00ff);
		jksq_far_end_i.pulse(1'b0);
		check("virgin test array", {out_bits, state_bits}, 16'h0000);
		jksq_far_end_i.pulse(1'b1);
		check("virgin second clock", {out_bits, state_bits}, 16'h0000);
	endtask

	task automatic t_init();
		set_fuse(1'b1, 1'b0, 1'b0);
		init_oe_pin = 1'b1;
		step(6);
		check("init preset", {out_bits, state_bits}, 16'h5a3c);
		check("pins at init", {7'h00, oe_b, pins_o}, 16'h005a);
		jksq_far_end_i.pulse(1'b0);
		check("clock during init", {out_bits, state_bits}, 16'h5a3c);
		init_oe_pin = 1'b0;
		step(6);
		// Clock 2 needs its own fall after init too; unused, it moves nothing
		jksq_far_end_i.pulse(1'b1);
		check("unused second clock", {out_bits, state_bits}, 16'h5a3c);
		jksq_far_end_i.pulse(1'b0);
		check("first rise after init", {out_bits, state_bits}, 16'h5a3c);
		jksq_far_end_i.pulse(1'b0);
		es = nxt(8'h3c, 8'hff);
		eo = nxt(8'h5a, 8'hff);
		check("jk update", {out_bits, state_bits}, {eo, es});
	endtask

	task automatic t_loads();
		out_load = 1'b1;
		step(5);
		check("float in output load", {7'h00, oe_b, 8'h00}, 16'h0100);
		jksq_far_end_i.drive(8'h69);
		step(3);
		jksq_far_end_i.pulse(1'b0);
		eo = 8'h69;
		check("output load", {out_bits, state_bits}, {eo, es});
		out_load = 1'b0;
		state_load = 1'b1;
		jksq_far_end_i.drive(8'h96);
		step(5);
		jksq_far_end_i.pulse(1'b0);
		es = 8'h96;
		check("state load", {out_bits, state_bits}, {eo, es});
		state_load = 1'b0;
		jksq_far_end_i.let_go();
		step(5);
	endtask

	task automatic t_view();
		state_view = 1'b1;
		step(5);
		check("view state", {7'h00, oe_b, pins_o}, {8'h00, es});
		jksq_far_end_i.pulse(1'b0);
		check("regs while viewing", {out_bits, state_bits}, {eo, es});
		state_view = 1'b0;
		step(5);
		check("pins show output reg", {7'h00, oe_b, pins_o}, {8'h00, eo});
	endtask

	task automatic t_second_clock();
		set_fuse(1'b1, 1'b0, 1'b1);
		jksq_far_end_i.pulse(1'b1);
		es = nxt(es, 8'hf0);
		eo = nxt(eo, 8'hf0);
		check("second clock lanes", {out_bits, state_bits}, {eo, es});
		jksq_far_end_i.pulse(1'b0);
		es = nxt(es, 8'h0f);
		eo = nxt(eo, 8'h0f);
		check("first clock lanes", {out_bits, state_bits}, {eo, es});
		out_load = 1'b1;
		jksq_far_end_i.drive(8'hc3);
		step(3);
		jksq_far_end_i.pulse(1'b1);
		eo = (eo & 8'h0f) | 8'hc0;
		check("load on second clock", {out_bits, state_bits}, {eo, es});
		out_load = 1'b0;
		jksq_far_end_i.let_go();
		step(5);
	endtask

	task automatic t_oe();
		set_fuse(1'b1, 1'b1, 1'b0);
		init_oe_pin = 1'b1;
		step(6);
		check("oe high floats", {7'h00, oe_b, 8'h00}, 16'h0100);
		check("oe keeps regs", {out_bits, state_bits}, {eo, es});
		init_oe_pin = 1'b0;
		step(5);
		check("oe low drives", {7'h00, oe_b, pins_o}, {8'h00, eo});
	endtask

	// Term 1 needs input 0 high; term 2 needs complement 0, the NOR of term 1
	task automatic t_terms();
		set_fuse(1'b1, 1'b0, 1'b0);
		fuse.term[1] = '0;
		fuse.term[1].true_m[0] = 1'b1;
		fuse.term[2] = '0;
		fuse.term[2].true_m[24] = 1'b1;
		fuse.comp_or[0][1] = 1'b1;
		fuse.j_or[0][1] = 1'b1;
		fuse.k_or[0][2] = 1'b1;
		logic_in = 16'h0001;
		step(3);
		jksq_far_end_i.pulse(1'b0);
		es = (nxt(es, 8'hff) & 8'hfe) | 8'h01;
		eo = nxt(eo, 8'hff);
		check("input term sets", {out_bits, state_bits}, {eo, es});
		logic_in = 16'h0000;
		step(3);
		jksq_far_end_i.pulse(1'b0);
		es = nxt(es, 8'hff) & 8'hfe;
		eo = nxt(eo, 8'hff);
		check("complement term clears", {out_bits, state_bits}, {eo, es});
	endtask

	initial begin
		set_fuse(1'b0, 1'b0, 1'b0);
		rst_b_i = 1'b0;
		init_oe_pin = 1'b0;
		logic_in = 16'h0000;
		out_load = 1'b0;
		state_load = 1'b0;
		state_view = 1'b0;
		es = 8'h00;
		eo = 8'h00;
		step(10);
		rst_b_i = 1'b1;
		step(1);
		t_reset_virgin();
		t_init();
		t_loads();
		t_view();
		t_second_clock();
		t_oe();
		t_terms();
		test_done();
	end
endmodule
